// ===== verilog/lpmc_pkg.sv
/*
 * Shared constants for the low power mode controller: power control bit positions,
 * reset value, mode states and reset qualification length.
 * Assumes a single 100 MHz clock standing in for the oscillator.
 */
package lpmc_pkg;
    localparam int LPMC_POWER_CONTROL_REGISTER_W = 8;
    localparam int LPMC_IDLE_BIT = 0;
    localparam int LPMC_PD_BIT = 1;
    localparam logic [7:0] LPMC_POWER_CONTROL_REGISTER_RST = 8'h00;
    // Clock period in ns and machine cycle length in clocks.
    localparam int LPMC_CLK_NS = 10;
    localparam int LPMC_MCYC_CLKS = 12;
    localparam int LPMC_RST_MCYC = 2;
    localparam int LPMC_RST_CLKS = LPMC_RST_MCYC * LPMC_MCYC_CLKS;
    typedef enum logic [1:0] {LPMC_RUN, LPMC_IDLE, LPMC_PDOWN} lpmc_mode_e;
endpackage : lpmc_pkg

// ===== verilog/lpmc_reset_filter.sv
/*
 * Reset pin qualifier: the pin must stay high for a full count of clocks.
 * Assumes the pin is asynchronous; it is synchronised here first.
 */
`timescale 1ns/1ps
module lpmc_reset_filter
    import lpmc_pkg::*;
#(
    parameter int HOLD_CLKS = LPMC_RST_CLKS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic resetPin,
    output logic hwReset
);
    logic sync1_q;
    logic sync2_q;
    logic [7:0] cnt_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= resetPin;
            sync2_q <= sync1_q;
        end
    end

    // Short glitches never reset the core; only a sustained high level does.
    always_ff @(posedge clock) begin
        if (reset || !sync2_q) begin
            cnt_q <= 8'h00;
            hwReset <= 1'b0;
        end else if (cnt_q < 8'(HOLD_CLKS - 1)) begin
            cnt_q <= cnt_q + 8'h01;
            hwReset <= 1'b0;
        end else begin
            hwReset <= 1'b1;
        end
    end
endmodule : lpmc_reset_filter

// ===== verilog/lpmc_core.sv
/*
 * Low power mode controller: idle and power-down entry from the power control
 * register, exit by enabled interrupt (idle) or qualified hardware reset, clock gating
 * enables and pin status overrides for the strobes and ports 0 to 3.
 * Assumes the CPU reports instruction completion and the peripheral core drives
 * the normal-mode pin values; clock gates are implemented outside with the enables.
 */
// Notes on behaviour
// - Idle stops CPU, peripherals keep running.
// - Idle entered after requesting instruction completes.
// - Idle keeps CPU, RAM, registers intact.
// - Enabled interrupt ends idle, vectors onward.
// - Reset in idle restarts like power-on.
// - Power-down stops oscillator after instruction.
// - Power-down keeps only data RAM; here powerControlRegister also keeps its value.
// - Only hardware reset ends power-down.
// - Idle internal: strobes high, ports hold data.
// - Idle external: strobes high, port0 floats.
// - Power-down internal: strobes low, ports hold.
// - Power-down external: strobes low, port0 floats.
// - Power control register bits select mode.
`timescale 1ns/1ps
module lpmc_core
    import lpmc_pkg::*;
#(
    parameter int RST_HOLD_CLKS = LPMC_RST_CLKS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic resetPin,
    input wire logic externalAccess,
    input wire logic pconWrite,
    input wire logic [7:0] pconWdata,
    input wire logic instrDone,
    input wire logic irqPending,
    input wire logic normAle,
    input wire logic normProgramFetchStrobe,
    input wire logic [7:0] normP0Out,
    input wire logic normP0Bus,
    input wire logic [7:0] p0Latch,
    input wire logic [7:0] p1Latch,
    input wire logic [7:0] p2Latch,
    input wire logic [7:0] p2Addr,
    input wire logic [7:0] p3Out,
    output logic [7:0] powerControlRegister,
    output logic cpuClockEnable,
    output logic periphClockEnable,
    output logic oscEnable,
    output logic coreReset,
    output logic wakeVector,
    output logic [1:0] modeState,
    output logic ale,
    output logic programFetchStrobe,
    output logic [7:0] p0Out,
    output logic [7:0] p0OutEnable_n,
    output logic [7:0] p1Out,
    output logic [7:0] p2Out,
    output logic [7:0] p3Pin
);
    lpmc_mode_e mode_q;
    logic hwReset;
    logic pendIdle_q;
    logic pendPd_q;
    logic extSync1_q;
    logic extSync2_q;
    logic [7:0] p3Hold_q;

    lpmc_reset_filter #(
        .HOLD_CLKS(RST_HOLD_CLKS)
    ) uResetFilter (
        .clock(clock),
        .reset(reset),
        .resetPin(resetPin),
        .hwReset(hwReset)
    );

    // The access strap is a pin, so it is synchronised before use.
    always_ff @(posedge clock) begin
        if (reset) begin
            extSync1_q <= 1'b0;
            extSync2_q <= 1'b0;
        end else begin
            extSync1_q <= externalAccess;
            extSync2_q <= extSync1_q;
        end
    end

    // Register write; hardware clears the idle bit on wake and all bits on reset.
    always_ff @(posedge clock) begin
        if (reset || hwReset) begin
            powerControlRegister <= LPMC_POWER_CONTROL_REGISTER_RST;
        end else if (mode_q == LPMC_IDLE && irqPending) begin
            powerControlRegister[LPMC_IDLE_BIT] <= 1'b0;
        end else if (pconWrite && mode_q == LPMC_RUN) begin
            powerControlRegister <= pconWdata;
        end
    end

    // A request is latched at the write and honoured only when that instruction ends.
    always_ff @(posedge clock) begin
        if (reset || hwReset || mode_q != LPMC_RUN) begin
            pendIdle_q <= 1'b0;
            pendPd_q <= 1'b0;
        end else if (pconWrite) begin
            pendIdle_q <= pconWdata[LPMC_IDLE_BIT];
            pendPd_q <= pconWdata[LPMC_PD_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (reset || hwReset) begin
            mode_q <= LPMC_RUN;
        end else begin
            case (mode_q)
                LPMC_RUN: begin
                    // Power-down wins when both bits are set.
                    if (instrDone && pendPd_q) begin
                        mode_q <= LPMC_PDOWN;
                    end else if (instrDone && pendIdle_q) begin
                        mode_q <= LPMC_IDLE;
                    end
                end
                LPMC_IDLE: begin
                    if (irqPending) begin
                        mode_q <= LPMC_RUN;
                    end
                end
                LPMC_PDOWN: begin
                    mode_q <= LPMC_PDOWN;
                end
                default: begin
                    mode_q <= LPMC_RUN;
                end
            endcase
        end
    end

    // Clock enables; CPU state and registers simply freeze while the CPU clock is off.
    always_ff @(posedge clock) begin
        if (reset) begin
            cpuClockEnable <= 1'b1;
            periphClockEnable <= 1'b1;
            oscEnable <= 1'b1;
            wakeVector <= 1'b0;
            coreReset <= 1'b1;
            modeState <= 2'h0;
        end else begin
            cpuClockEnable <= (mode_q == LPMC_RUN);
            periphClockEnable <= (mode_q != LPMC_PDOWN);
            oscEnable <= (mode_q != LPMC_PDOWN);
            wakeVector <= (mode_q == LPMC_IDLE) && irqPending && !hwReset;
            coreReset <= hwReset;
            modeState <= 2'(mode_q);
        end
    end

    // Port 3 alternate outputs are frozen at entry to power-down.
    always_ff @(posedge clock) begin
        if (reset) begin
            p3Hold_q <= 8'hff;
        end else if (mode_q != LPMC_PDOWN) begin
            p3Hold_q <= p3Out;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ale <= 1'b1;
            programFetchStrobe <= 1'b1;
            p0Out <= 8'hff;
            p0OutEnable_n <= 8'hff;
            p1Out <= 8'hff;
            p2Out <= 8'hff;
            p3Pin <= 8'hff;
        end else begin
            case (mode_q)
                LPMC_IDLE: begin
                    ale <= 1'b1;
                    programFetchStrobe <= 1'b1;
                    p0Out <= p0Latch;
                    // With internal memory the latch byte is driven in full, so the pins show data.
                    p0OutEnable_n <= extSync2_q ? 8'hff : 8'h00;
                    p1Out <= p1Latch;
                    p2Out <= extSync2_q ? p2Addr : p2Latch;
                    p3Pin <= p3Out;
                end
                LPMC_PDOWN: begin
                    ale <= 1'b0;
                    programFetchStrobe <= 1'b0;
                    p0Out <= p0Latch;
                    p0OutEnable_n <= extSync2_q ? 8'hff : 8'h00;
                    p1Out <= p1Latch;
                    p2Out <= p2Latch;
                    p3Pin <= p3Hold_q;
                end
                default: begin
                    ale <= normAle;
                    programFetchStrobe <= normProgramFetchStrobe;
                    p0Out <= normP0Bus ? normP0Out : p0Latch;
                    // Port 0 is open drain unless it is carrying the bus: a latched 1 floats.
                    p0OutEnable_n <= normP0Bus ? 8'h00 : p0Latch;
                    p1Out <= p1Latch;
                    p2Out <= p2Latch;
                    p3Pin <= p3Out;
                end
            endcase
        end
    end
endmodule : lpmc_core

// ===== verif/lpmc_asserts.sv
/* Checker for the low power mode controller ports.
   Assumes it is bound to lpmc_core and sees only that module's ports. */
`timescale 1ns/1ps
module lpmc_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic instrDone,
    input wire logic irqPending,
    input wire logic [7:0] p1Latch,
    input wire logic [7:0] powerControlRegister,
    input wire logic cpuClockEnable,
    input wire logic periphClockEnable,
    input wire logic oscEnable,
    input wire logic coreReset,
    input wire logic wakeVector,
    input wire logic [1:0] modeState,
    input wire logic ale,
    input wire logic programFetchStrobe,
    input wire logic [7:0] p1Out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire logic run = modeState == 2'h0 && !coreReset;
    wire logic [1:0] bits = powerControlRegister[1:0];
    // The mode output and the pin outputs come from the same register stage, one edge after the mode.
    sequence s_woken;
        wakeVector && !powerControlRegister[0];
    endsequence
    sequence s_cpu_back;
        modeState == 2'h0 && cpuClockEnable;
    endsequence
    AST_IDLE_CLK: assert property (modeState == 2'h1 |-> !cpuClockEnable && periphClockEnable)
        else $error("cpu clock runs in idle");
    AST_IDLE_ENTRY: assert property (run && instrDone && bits == 2'h1 |-> ##2 modeState == 2'h1)
        else $error("idle not entered");
    AST_PD_ENTRY: assert property (run && instrDone && bits[1] |-> ##2 modeState == 2'h2)
        else $error("power-down not entered");
    AST_NO_EARLY: assert property (run && !instrDone && !$past(instrDone) |=> modeState == 2'h0)
        else $error("mode left before instruction end");
    AST_WAKE: assert property (modeState == 2'h1 && irqPending && !coreReset |=> s_woken ##1 s_cpu_back)
        else $error("interrupt wake wrong");
    AST_PD_STAY: assert property (modeState == 2'h2 && !coreReset |=> modeState == 2'h2 || coreReset)
        else $error("power-down left without reset");
    AST_IDLE_PINS: assert property (modeState == 2'h1 |-> ale && programFetchStrobe && p1Out == $past(p1Latch))
        else $error("idle pin status wrong");
    AST_PD_PINS: assert property (modeState == 2'h2 |-> !ale && !programFetchStrobe && !oscEnable)
        else $error("power-down pin status wrong");
    AST_HW_RESET: assert property (coreReset |=> modeState == 2'h0)
        else $error("reset does not restart");
endmodule : lpmc_asserts
bind lpmc_core lpmc_asserts u_chk (
    .clock(clock), .reset(reset), .instrDone(instrDone), .irqPending(irqPending), .p1Latch(p1Latch),
    .powerControlRegister(powerControlRegister), .cpuClockEnable(cpuClockEnable),
    .periphClockEnable(periphClockEnable), .oscEnable(oscEnable), .coreReset(coreReset),
    .wakeVector(wakeVector), .modeState(modeState), .ale(ale), .programFetchStrobe(programFetchStrobe),
    .p1Out(p1Out)
);

// ===== verif/lpmc_bus_model.sv
/* External memory on port 0.
   Assumes the controller drives port 0 with active-low enables. */
`timescale 1ns/1ps
module lpmc_bus_model (
    input wire logic clock,
    input wire logic ale,
    input wire logic programFetchStrobe,
    input wire logic [7:0] p0Out,
    input wire logic [7:0] p0OutEnable_n,
    output logic [7:0] p0Wire
);
    logic [7:0] addr_q;
    logic [7:0] last_q;
    always_ff @(posedge clock) begin
        if (ale) begin
            addr_q <= p0Out;
        end
        last_q <= p0Wire;
    end
    // A floating line shows the inverse of its last level, or of the latched address while programFetchStrobe is low, so stale data can never pass for driven data.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p0Wire[i] = !p0OutEnable_n[i] ? p0Out[i] : (!programFetchStrobe ? ~addr_q[i] : ~last_q[i]);
        end
    end
endmodule : lpmc_bus_model

// ===== verif/low_power_mode_control_tb.sv
/* Self-checking bench for the low power mode controller.
   Assumes the checker is bound and the bus model sits on port 0. */
`timescale 1ns/1ps
module low_power_mode_control_tb;
    import lpmc_pkg::*;
    logic clock = 1'b0, reset = 1'b1, resetPin = 1'b0, externalAccess = 1'b0, pconWrite = 1'b0;
    logic instrDone = 1'b0, irqPending = 1'b0, normAle = 1'b0, normProgramFetchStrobe = 1'b1, normP0Bus = 1'b0;
    logic [7:0] pconWdata = 8'h00, normP0Out = 8'h11, p0Latch = 8'h5a, p1Latch = 8'h3c;
    logic [7:0] p2Latch = 8'hc3, p2Addr = 8'h81, p3Out = 8'h96;
    logic [7:0] powerControlRegister, p0Out, p0OutEnable_n, p1Out, p2Out, p3Pin, p0Wire;
    logic cpuClockEnable, periphClockEnable, oscEnable, coreReset, wakeVector, ale, programFetchStrobe;
    logic [1:0] modeState;
    int bad_count = 0, check_count = 0;
    lpmc_core dut (
        .clock(clock), .reset(reset), .resetPin(resetPin), .externalAccess(externalAccess),
        .pconWrite(pconWrite), .pconWdata(pconWdata), .instrDone(instrDone), .irqPending(irqPending),
        .normAle(normAle), .normProgramFetchStrobe(normProgramFetchStrobe), .normP0Out(normP0Out),
        .normP0Bus(normP0Bus), .p0Latch(p0Latch), .p1Latch(p1Latch), .p2Latch(p2Latch), .p2Addr(p2Addr),
        .p3Out(p3Out), .powerControlRegister(powerControlRegister), .cpuClockEnable(cpuClockEnable),
        .periphClockEnable(periphClockEnable), .oscEnable(oscEnable), .coreReset(coreReset),
        .wakeVector(wakeVector), .modeState(modeState), .ale(ale), .programFetchStrobe(programFetchStrobe),
        .p0Out(p0Out), .p0OutEnable_n(p0OutEnable_n), .p1Out(p1Out), .p2Out(p2Out), .p3Pin(p3Pin)
    );
    lpmc_bus_model mem (
        .clock(clock), .ale(ale), .programFetchStrobe(programFetchStrobe), .p0Out(p0Out),
        .p0OutEnable_n(p0OutEnable_n), .p0Wire(p0Wire)
    );
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic enter(input logic [7:0] bits, input logic ext);
        externalAccess = ext;
        tick(4);
        pconWdata = bits;
        pconWrite = 1'b1;
        tick(1);
        pconWrite = 1'b0;
        tick(2);
        check(8'(modeState), 8'(LPMC_RUN));
        instrDone = 1'b1;
        tick(1);
        instrDone = 1'b0;
        tick(2);
    endtask : enter
    task automatic hw_reset;
        int n;
        resetPin = 1'b1;
        for (n = 0; n < 40 && coreReset !== 1'b1; n++) begin
            tick(1);
        end
        resetPin = 1'b0;
        // Two synchroniser stages and the output register come on top of the qualifying count.
        check(8'(n), 8'(LPMC_RST_CLKS + 3));
        tick(6);
        check(8'(modeState), 8'(LPMC_RUN));
        check({4'h0, cpuClockEnable, oscEnable, powerControlRegister[1:0]}, 8'h0c);
        check({6'h00, ale, programFetchStrobe}, {6'h00, normAle, normProgramFetchStrobe});
        check(p0OutEnable_n, p0Latch);
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
    endtask : hw_reset
    task automatic idle_case(input logic ext);
        enter(8'h01, ext);
        check(8'(modeState), 8'(LPMC_IDLE));
        check({4'h0, cpuClockEnable, periphClockEnable, ale, programFetchStrobe}, 8'h07);
        check(powerControlRegister, 8'h01);
        check(p1Out, p1Latch);
        check(p2Out, ext ? p2Addr : p2Latch);
        check(p0OutEnable_n, ext ? 8'hff : 8'h00);
        check(p3Pin, p3Out);
        if (!ext) check(p0Wire, p0Latch);
        if (!ext) check(p0Out, p0Latch);
        irqPending = 1'b1;
        tick(1);
        irqPending = 1'b0;
        check({7'h00, wakeVector}, 8'h01);
        check(powerControlRegister, 8'h00);
        tick(1);
        check({7'h00, cpuClockEnable}, 8'h01);
        check({7'h00, wakeVector}, 8'h00);
    endtask : idle_case
    task automatic pd_case(input logic ext);
        enter(8'h03, ext);
        check(8'(modeState), 8'(LPMC_PDOWN));
        check({4'h0, oscEnable, periphClockEnable, ale, programFetchStrobe}, 8'h00);
        check(p0OutEnable_n, ext ? 8'hff : 8'h00);
        check(p1Out, p1Latch);
        check(p2Out, p2Latch);
        p3Out = ~p3Out;
        irqPending = 1'b1;
        pconWdata = 8'h00;
        pconWrite = 1'b1;
        tick(1);
        pconWrite = 1'b0;
        tick(2);
        irqPending = 1'b0;
        check(p3Pin, ~p3Out);
        check(8'(modeState), 8'(LPMC_PDOWN));
        check(powerControlRegister, 8'h03);
        check({7'h00, wakeVector}, 8'h00);
        hw_reset();
    endtask : pd_case
    initial begin
        tick(20);
        reset = 1'b0;
        tick(2);
        for (int e = 0; e < 2; e++) begin
            idle_case(e[0]);
            enter(8'h01, e[0]);
            hw_reset();
            pd_case(e[0]);
        end
        wrap_up();
    end
endmodule : low_power_mode_control_tb
